// ---- logic/dcw_regs.svh ----
// register offsets, field positions, reset values and timing constants
`ifndef DCW_REGS_SVH
`define DCW_REGS_SVH

`define DCW_OFF_CTRL_WORD 12'h000
`define DCW_OFF_CW_ENABLE 12'h004
`define DCW_OFF_SUPPLY 12'h008
`define DCW_OFF_EVENT 12'h00C
`define DCW_OFF_IRQ_STATUS 12'h010
`define DCW_OFF_IRQ_MASK 12'h014
`define DCW_OFF_SEQ_PARAMS 12'h018
`define DCW_OFF_DRIVE_STATUS 12'h01C
`define DCW_OFF_DRIVE_CMD 12'h020

`define DCW_CW_MAX 16'h7FFF
`define DCW_CW_RESET 16'h0000
`define DCW_BIT_AUTO 7
`define DCW_BIT_REF 8
`define DCW_BIT_JOGREV 9
`define DCW_BIT_TRIP 12
`define DCW_BIT_RESET 13
`define DCW_BIT_WDOG 14
`define DCW_SEQ_REGEN_MASK 8'h7F

`define DCW_IRQ_WDOG_TRIP 0
`define DCW_IRQ_CW_TRIP 1
`define DCW_IRQ_RESET 2
`define DCW_IRQ_MODE_CHG 3
`define DCW_IRQ_SAVE 4
`define DCW_IRQ_W 5

`define DCW_CLK_HZ 10000000
`define DCW_FAST_TICK_US 4000
`define DCW_BG_TICK_US 16000
`define DCW_WDOG_MS 1000
`define DCW_GRACE_MS 2000
`define DCW_STALL_MS 1500

`endif

// ---- logic/dcw_pkg.sv ----
// types shared by the drive control word unit
package dcw_pkg;
  typedef struct packed {
    logic drive_enable;
    logic run_fwd;
    logic jog;
    logic run_rev;
    logic fwd_rev;
    logic run;
    logic not_stop;
    logic jog_reverse;
  } dcw_seq_t;

  typedef struct packed {
    logic control_word_trip;
    logic wdog_trip;
    logic drive_reset;
    logic power_down_save;
  } dcw_evt_t;
endpackage

// ---- logic/dcw_unit.sv ----
// drive control word unit: apb registers, sequencing override, watchdog
`timescale 1ns/1ps
`default_nettype none
`include "dcw_regs.svh"

module dcw_unit #(
  parameter int FAST_TICK_CYC = `DCW_CLK_HZ / 1000000 * `DCW_FAST_TICK_US,
  parameter int BG_TICK_CYC = `DCW_CLK_HZ / 1000000 * `DCW_BG_TICK_US,
  parameter int WDOG_CYC = `DCW_CLK_HZ / 1000 * `DCW_WDOG_MS,
  parameter int GRACE_CYC = `DCW_CLK_HZ / 1000 * `DCW_GRACE_MS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic regen_mode,
  input wire logic mode_change_saved,
  input wire logic comms_resumed,
  input wire logic undervoltage_trip,
  input wire logic battery_supply,
  output dcw_pkg::dcw_seq_t seq_out,
  output logic reference_select_param,
  output dcw_pkg::dcw_evt_t evt_out,
  output logic irq
);
  import dcw_pkg::*;

  // ************************************************
  // pin synchronisers
  // ************************************************
  logic [4:0] sync1_reg, sync2_reg;
  logic [4:0] pins;
  assign pins = {regen_mode, mode_change_saved, comms_resumed,
                 undervoltage_trip, battery_supply};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= 5'h0;
      sync2_reg <= 5'h0;
    end else begin
      sync1_reg <= pins;
      sync2_reg <= sync1_reg;
    end
  end
  logic regen_s, mode_saved_s, resumed_s, uv_s, batt_s;
  assign {regen_s, mode_saved_s, resumed_s, uv_s, batt_s} = sync2_reg;

  // ************************************************
  // registers and state
  // ************************************************
  logic [15:0] cw_reg, cw_next;
  logic en_reg, en_next;
  logic [7:0] seq_param_reg, seq_param_next;
  logic [7:0] lo_smp_reg, lo_smp_next;
  logic [7:0] hi_smp_reg, hi_smp_next;
  logic [7:0] hi_prev_reg, hi_prev_next;
  logic hi_valid_reg, hi_valid_next;
  logic [31:0] fast_cnt_reg, fast_cnt_next;
  logic [31:0] bg_cnt_reg, bg_cnt_next;
  logic [31:0] wd_cnt_reg, wd_cnt_next;
  logic [31:0] grace_cnt_reg, grace_cnt_next;
  logic wd_armed_reg, wd_armed_next;
  logic wd_trip_reg, wd_trip_next;
  logic cw_trip_reg, cw_trip_next;
  logic mode_flag_reg, mode_flag_next;
  logic supply_reg, supply_next;
  logic uv_prev_reg, uv_prev_next;
  logic mode_prev_reg, mode_prev_next;
  logic [`DCW_IRQ_W-1:0] ist_reg, ist_next, imask_reg, imask_next;
  dcw_seq_t seq_reg, seq_next;
  logic ref_reg, ref_next;
  dcw_evt_t evt_reg, evt_next;
  logic [31:0] prdata_reg, prdata_next;
  logic irq_reg, irq_next;

  logic wr, rd, fast_tick, bg_tick, rst_edge, wd_edge, rst_pulse, save_pulse;
  logic trip_clr, mode_rise, wd_timeout;
  logic [`DCW_IRQ_W-1:0] ev_set;
  logic [7:0] sel_seq;
  logic [7:0] cw_seq;
  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;

  // ************************************************
  // next-state logic
  // ************************************************
  always_comb begin
    cw_next = cw_reg;
    en_next = en_reg;
    seq_param_next = seq_param_reg;
    imask_next = imask_reg;
    trip_clr = 1'b0;
    if (wr) begin
      unique case (paddr)
        `DCW_OFF_CTRL_WORD: cw_next = pwdata[15:0] & `DCW_CW_MAX;
        `DCW_OFF_CW_ENABLE: en_next = pwdata[0];
        `DCW_OFF_SEQ_PARAMS: seq_param_next = pwdata[7:0];
        `DCW_OFF_IRQ_MASK: imask_next = pwdata[`DCW_IRQ_W-1:0];
        `DCW_OFF_DRIVE_CMD: trip_clr = pwdata[0];
        default: ;
      endcase
    end

    // periodic sampling ticks
    fast_tick = fast_cnt_reg == 32'(FAST_TICK_CYC - 1);
    bg_tick = bg_cnt_reg == 32'(BG_TICK_CYC - 1);
    fast_cnt_next = fast_tick ? 32'h0000_0000 : fast_cnt_reg + 32'h0000_0001;
    bg_cnt_next = bg_tick ? 32'h0000_0000 : bg_cnt_reg + 32'h0000_0001;
    lo_smp_next = fast_tick ? cw_reg[7:0] : lo_smp_reg;
    hi_smp_next = bg_tick ? cw_reg[15:8] : hi_smp_reg;
    hi_prev_next = bg_tick ? hi_smp_reg : hi_prev_reg;
    hi_valid_next = hi_valid_reg | bg_tick;

    // edges: watchdog bit from new sample against previous sample, reset pulse from live word against sample
    rst_edge = hi_smp_reg[`DCW_BIT_RESET-8] &&
               !hi_prev_reg[`DCW_BIT_RESET-8];
    wd_edge = hi_smp_reg[`DCW_BIT_WDOG-8] &&
              !hi_prev_reg[`DCW_BIT_WDOG-8];
    rst_pulse = bg_tick && en_reg && hi_valid_reg &&
                cw_reg[`DCW_BIT_RESET] &&
                !hi_smp_reg[`DCW_BIT_RESET-8];

    // sequencing override
    cw_seq = {lo_smp_reg[0], lo_smp_reg[1], lo_smp_reg[2], lo_smp_reg[3],
              lo_smp_reg[4], lo_smp_reg[5], lo_smp_reg[6],
              hi_smp_reg[`DCW_BIT_JOGREV-8]};
    if (regen_s) begin
      cw_seq = cw_seq & ~`DCW_SEQ_REGEN_MASK | (seq_param_reg &
               `DCW_SEQ_REGEN_MASK);
    end
    if (en_reg && lo_smp_reg[`DCW_BIT_AUTO]) begin
      sel_seq = cw_seq;
    end else begin
      sel_seq = seq_param_reg;
    end
    seq_next = dcw_seq_t'(sel_seq);
    ref_next = ref_reg;
    if (en_reg && !regen_s) begin
      ref_next = hi_smp_reg[`DCW_BIT_REF-8];
    end

    // trip from bit 12
    cw_trip_next = cw_trip_reg;
    if (en_reg && hi_smp_reg[`DCW_BIT_TRIP-8]) begin
      cw_trip_next = 1'b1;
    end else if (trip_clr) begin
      cw_trip_next = 1'b0;
    end

    // watchdog
    wd_armed_next = wd_armed_reg;
    wd_trip_next = wd_trip_reg;
    wd_cnt_next = wd_cnt_reg;
    grace_cnt_next = grace_cnt_reg;
    wd_timeout = 1'b0;
    if (resumed_s) begin
      grace_cnt_next = 32'(GRACE_CYC);
    end else if (grace_cnt_reg != 32'h0000_0000) begin
      grace_cnt_next = grace_cnt_reg - 32'h0000_0001;
    end
    if (trip_clr && !(en_reg && hi_smp_reg[`DCW_BIT_TRIP-8])) begin
      wd_trip_next = 1'b0;
    end
    if (bg_tick && en_reg && hi_valid_reg && wd_edge) begin
      wd_armed_next = 1'b1;
      wd_cnt_next = 32'h0000_0000;
    end else if (wd_armed_reg) begin
      if (grace_cnt_reg != 32'h0000_0000) begin
        wd_cnt_next = 32'h0000_0000;
      end else if (wd_cnt_reg == 32'(WDOG_CYC - 1)) begin
        wd_timeout = 1'b1;
        wd_trip_next = 1'b1;
        wd_armed_next = 1'b0;
        wd_cnt_next = 32'h0000_0000;
      end else begin
        wd_cnt_next = wd_cnt_reg + 32'h0000_0001;
      end
    end

    // event flag, supply indicator, power-down save
    mode_prev_next = mode_saved_s;
    mode_rise = mode_saved_s && !mode_prev_reg;
    mode_flag_next = mode_flag_reg | mode_rise;
    uv_prev_next = uv_s;
    supply_next = supply_reg;
    if (uv_prev_reg && !uv_s) begin
      supply_next = batt_s;
    end
    save_pulse = uv_s && !uv_prev_reg && !supply_reg;

    evt_next.control_word_trip = cw_trip_next;
    evt_next.wdog_trip = wd_trip_next;
    evt_next.drive_reset = rst_pulse;
    evt_next.power_down_save = save_pulse;

    // interrupt status: set wins over write-one-to-clear
    ev_set = '0;
    ev_set[`DCW_IRQ_WDOG_TRIP] = wd_timeout;
    ev_set[`DCW_IRQ_CW_TRIP] = cw_trip_next && !cw_trip_reg;
    ev_set[`DCW_IRQ_RESET] = rst_pulse;
    ev_set[`DCW_IRQ_MODE_CHG] = mode_rise;
    ev_set[`DCW_IRQ_SAVE] = save_pulse;
    ist_next = ist_reg;
    if (wr && paddr == `DCW_OFF_IRQ_STATUS) begin
      ist_next = ist_reg & ~pwdata[`DCW_IRQ_W-1:0];
    end
    ist_next = ist_next | ev_set;
    irq_next = |(ist_next & imask_next);

    // read data captured in setup phase
    prdata_next = prdata_reg;
    if (rd) begin
      unique case (paddr)
        `DCW_OFF_CTRL_WORD: prdata_next = {16'h0000, cw_reg};
        `DCW_OFF_CW_ENABLE: prdata_next = {31'h0, en_reg};
        `DCW_OFF_SUPPLY: prdata_next = {31'h0, supply_reg};
        `DCW_OFF_EVENT: prdata_next = {30'h0, mode_flag_reg, 1'b0};
        `DCW_OFF_IRQ_STATUS: prdata_next = {27'h0, ist_reg};
        `DCW_OFF_IRQ_MASK: prdata_next = {27'h0, imask_reg};
        `DCW_OFF_SEQ_PARAMS: prdata_next = {24'h0, seq_param_reg};
        `DCW_OFF_DRIVE_STATUS:
          prdata_next = {28'h0, wd_armed_reg, wd_trip_reg,
                         cw_trip_reg, ref_reg};
        default: prdata_next = 32'h0000_0000;
      endcase
    end
  end

  // ************************************************
  // state registers
  // ************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cw_reg <= `DCW_CW_RESET;
      en_reg <= 1'b0;
      seq_param_reg <= 8'h00;
      lo_smp_reg <= 8'h00;
      hi_smp_reg <= 8'h00;
      hi_prev_reg <= 8'h00;
      hi_valid_reg <= 1'b0;
      fast_cnt_reg <= 32'h0000_0000;
      bg_cnt_reg <= 32'h0000_0000;
      wd_cnt_reg <= 32'h0000_0000;
      grace_cnt_reg <= 32'h0000_0000;
      wd_armed_reg <= 1'b0;
      wd_trip_reg <= 1'b0;
      cw_trip_reg <= 1'b0;
      mode_flag_reg <= 1'b0;
      supply_reg <= 1'b0;
      uv_prev_reg <= 1'b0;
      mode_prev_reg <= 1'b0;
      ist_reg <= '0;
      imask_reg <= '0;
      seq_reg <= '0;
      ref_reg <= 1'b0;
      evt_reg <= '0;
      prdata_reg <= 32'h0000_0000;
      irq_reg <= 1'b0;
    end else begin
      cw_reg <= cw_next;
      en_reg <= en_next;
      seq_param_reg <= seq_param_next;
      lo_smp_reg <= lo_smp_next;
      hi_smp_reg <= hi_smp_next;
      hi_prev_reg <= hi_prev_next;
      hi_valid_reg <= hi_valid_next;
      fast_cnt_reg <= fast_cnt_next;
      bg_cnt_reg <= bg_cnt_next;
      wd_cnt_reg <= wd_cnt_next;
      grace_cnt_reg <= grace_cnt_next;
      wd_armed_reg <= wd_armed_next;
      wd_trip_reg <= wd_trip_next;
      cw_trip_reg <= cw_trip_next;
      mode_flag_reg <= mode_flag_next;
      supply_reg <= supply_next;
      uv_prev_reg <= uv_prev_next;
      mode_prev_reg <= mode_prev_next;
      ist_reg <= ist_next;
      imask_reg <= imask_next;
      seq_reg <= seq_next;
      ref_reg <= ref_next;
      evt_reg <= evt_next;
      prdata_reg <= prdata_next;
      irq_reg <= irq_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign seq_out = seq_reg;
  assign reference_select_param = ref_reg;
  assign evt_out = evt_reg;
  assign irq = irq_reg;
endmodule
`default_nettype wire

// ---- testbench/dcw_unit_assertions.sv ----
// checker for the drive control word unit
`timescale 1ns/1ps
`default_nettype none
`include "dcw_regs.svh"
module dcw_unit_assertions #(parameter int WDOG_CYC = 200) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic regen_mode,
  input wire dcw_pkg::dcw_seq_t seq_out,
  input wire dcw_pkg::dcw_evt_t evt_out,
  input wire logic irq
);
  import dcw_pkg::*;
  // ****
  // cycles since last watchdog service write
  // ****
  logic acc, cmd_w, svc;
  int unsigned idle_reg, idle_next;
  assign acc = psel && penable && pwrite;
  assign cmd_w = acc && paddr == `DCW_OFF_DRIVE_CMD && pwdata[0];
  assign svc = acc && paddr == `DCW_OFF_CTRL_WORD && pwdata[14];
  always_comb idle_next = svc ? 0 : idle_reg + 1;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) idle_reg <= 0;
    else idle_reg <= idle_next;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ****
  // properties
  // ****
  property p_quiet;
    disable iff (1'b0) !presetn |=> seq_out == 0 && evt_out == 0 && !irq;
  endproperty
  property p_rst_pulse;
    $rose(evt_out.drive_reset) |=> !evt_out.drive_reset;
  endproperty
  property p_save_pulse;
    $rose(evt_out.power_down_save) |=> !evt_out.power_down_save;
  endproperty
  property p_wd_clr;
    $fell(evt_out.wdog_trip) |-> $past(cmd_w) || $past(cmd_w, 2);
  endproperty
  property p_cw_clr;
    $fell(evt_out.control_word_trip) |-> $past(cmd_w) || $past(cmd_w, 2);
  endproperty
  property p_regen;
    (regen_mode && !psel) [*5] |=> $stable(seq_out[6:0]);
  endproperty
  property p_wdog;
    $rose(evt_out.wdog_trip) |-> idle_reg >= WDOG_CYC;
  endproperty
  property p_apb;
    psel && penable |-> pready && !pslverr;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("outputs not clear in reset");
  a_rst_pulse: assert property (p_rst_pulse)
    else $error("drive reset pulse too long");
  a_save_pulse: assert property (p_save_pulse)
    else $error("save pulse too long");
  a_wd_clr: assert property (p_wd_clr)
    else $error("watchdog trip cleared without reset");
  a_cw_clr: assert property (p_cw_clr)
    else $error("word trip cleared without reset");
  a_regen: assert property (p_regen)
    else $error("sequencing moved in regen");
  a_wdog: assert property (p_wdog)
    else $error("watchdog tripped early");
  a_apb: assert property (p_apb)
    else $error("bus answer wrong");
  c_rst: cover property ($rose(evt_out.drive_reset));
  c_wd: cover property ($rose(evt_out.wdog_trip));
  c_cw: cover property ($rose(evt_out.control_word_trip));
endmodule
`default_nettype wire

// ---- testbench/dcw_plant.sv ----
// plant model: regen, mode, comms, supply levels seen by the unit
`timescale 1ns/1ps
`default_nettype none
module dcw_plant (
  input wire logic pclk,
  input wire logic [4:0] req,
  output logic [4:0] pins
);
  logic [4:0] pins_next;
  // supply kind only changes while no undervoltage trip
  always_comb pins_next = {req[4:1], req[1] ? pins[0] : req[0]};
  always_ff @(posedge pclk) pins <= pins_next;
endmodule
`default_nettype wire

// ---- testbench/dcw_unit_bench.sv ----
// self-checking bench for the drive control word unit
`timescale 1ns/1ps
`default_nettype none
`include "dcw_regs.svh"
module dcw_unit_bench;
  import dcw_pkg::*;
  // ****
  // signals and instances
  // ****
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, probe = 1'b0, pready, pslverr, irq, ref_sel;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [4:0] req = 5'h0, pins;
  dcw_seq_t seq_out;
  dcw_evt_t evt_out;
  logic [31:0] q[$];
  int err_total = 0, num_checks = 0;
  logic [7:0] r;
  logic [15:0] c;
  always #50 pclk = ~pclk;
  dcw_unit #(.FAST_TICK_CYC(8), .BG_TICK_CYC(16), .WDOG_CYC(200),
    .GRACE_CYC(100)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .regen_mode(pins[4]), .mode_change_saved(pins[3]),
    .comms_resumed(pins[2]), .undervoltage_trip(pins[1]),
    .battery_supply(pins[0]), .seq_out(seq_out),
    .reference_select_param(ref_sel), .evt_out(evt_out), .irq(irq));
  dcw_plant plant (.pclk(pclk), .req(req), .pins(pins));
  // ****
  // tasks
  // ****
  task automatic chk(input string n, input logic [31:0] s, e);
    num_checks++;
    if (s !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (n >= 50) begin
      err_total++;
      complete_run();
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    q.push_back(e);
    xfer(1'b0, a, 32'h0);
  endtask
  task automatic see(input logic [31:0] e);
    q.push_back(e);
    probe <= 1'b1;
    @(posedge pclk);
    probe <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wev(input int b);
    int n;
    for (n = 0; n < 600 && evt_out[b] !== 1'b1; n++) @(negedge pclk);
    chk("event", {31'h0, evt_out[b]}, 32'h1);
    @(posedge pclk);
    if (n == 600) complete_run();
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask
  function automatic logic [7:0] mp(input logic [15:0] w);
    return {w[0], w[1], w[2], w[3], w[4], w[5], w[6], w[9]};
  endfunction
  always @(posedge pclk) begin
    if (psel && penable && !pwrite && pready === 1'b1)
      chk("prdata", prdata, q.pop_front());
    if (probe)
      chk("outputs", {18'h0, irq, evt_out, ref_sel, seq_out}, q.pop_front());
  end
  // ****
  // scenarios
  // ****
  initial begin
    r = 8'($urandom(32'h0800_000c));
    idle(12);
    presetn <= 1'b1;
    idle(1);
    rd(`DCW_OFF_CTRL_WORD, 32'h0);
    rd(`DCW_OFF_CW_ENABLE, 32'h0);
    rd(`DCW_OFF_EVENT, 32'h0);
    rd(12'h03C, 32'h0);
    see(32'h0);
    $display("test reset done");
    r = 8'($urandom);
    c = (16'($urandom) & 16'h037F) | 16'h0080;
    wr(`DCW_OFF_SEQ_PARAMS, {24'h0, r});
    wr(`DCW_OFF_CTRL_WORD, {16'h0, c});
    idle(40);
    see({24'h0, r});
    wr(`DCW_OFF_CW_ENABLE, 32'h1);
    idle(40);
    see({23'h0, c[8], mp(c)});
    rd(`DCW_OFF_SEQ_PARAMS, {24'h0, r});
    wr(`DCW_OFF_CTRL_WORD, {16'h0, c & 16'hFF7F});
    idle(40);
    see({23'h0, c[8], r});
    $display("test sequencing done");
    wr(`DCW_OFF_CTRL_WORD, 32'h2000);
    wev(1);
    wr(`DCW_OFF_IRQ_STATUS, 32'h1F);
    wr(`DCW_OFF_CTRL_WORD, 32'h1000);
    wev(3);
    see({18'h0, 1'b0, 4'h8, 1'b0, r});
    wr(`DCW_OFF_IRQ_MASK, 32'h2);
    see({18'h0, 1'b1, 4'h8, 1'b0, r});
    wr(`DCW_OFF_DRIVE_CMD, 32'h1);
    idle(40);
    rd(`DCW_OFF_DRIVE_STATUS, 32'h2);
    wr(`DCW_OFF_CTRL_WORD, 32'h0);
    idle(40);
    wr(`DCW_OFF_DRIVE_CMD, 32'h1);
    wr(`DCW_OFF_IRQ_STATUS, 32'h1F);
    see({24'h0, r});
    $display("test trips done");
    req <= 5'h02;
    wev(0);
    req <= 5'h03;
    idle(2);
    req <= 5'h01;
    idle(8);
    rd(`DCW_OFF_SUPPLY, 32'h1);
    req <= 5'h02;
    idle(8);
    req <= 5'h00;
    idle(8);
    rd(`DCW_OFF_SUPPLY, 32'h0);
    $display("test supply done");
    req <= 5'h08;
    idle(8);
    rd(`DCW_OFF_EVENT, 32'h2);
    wr(`DCW_OFF_EVENT, 32'h0);
    rd(`DCW_OFF_EVENT, 32'h2);
    $display("test mode flag done");
    req <= 5'h18;
    idle(10);
    wr(`DCW_OFF_CTRL_WORD, {16'h0, c});
    idle(40);
    see({23'h0, 1'b0, c[0], r[6:0]});
    req <= 5'h08;
    wr(`DCW_OFF_CTRL_WORD, 32'h0);
    $display("test regen done");
    repeat (3) begin
      idle(20);
      wr(`DCW_OFF_CTRL_WORD, 32'h4000);
      idle(120);
      wr(`DCW_OFF_CTRL_WORD, 32'h0);
    end
    rd(`DCW_OFF_DRIVE_STATUS, 32'h8);
    see({24'h0, r});
    wev(2);
    rd(`DCW_OFF_DRIVE_STATUS, 32'h4);
    wr(`DCW_OFF_DRIVE_CMD, 32'h1);
    idle(20);
    wr(`DCW_OFF_CTRL_WORD, 32'h4000);
    idle(40);
    rd(`DCW_OFF_DRIVE_STATUS, 32'h8);
    req <= 5'h0C;
    idle(4);
    req <= 5'h08;
    idle(250);
    rd(`DCW_OFF_DRIVE_STATUS, 32'h8);
    $display("test watchdog done");
    complete_run();
  end
endmodule
bind dcw_unit dcw_unit_assertions #(.WDOG_CYC(WDOG_CYC)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .regen_mode(regen_mode), .seq_out(seq_out),
  .evt_out(evt_out), .irq(irq));
`default_nettype wire
